// ==== hdl/pfm_consts.vh ====
/*
  constants for the pump fault manager: register map, fault codes,
  menu states and timing. assumes a 200 MHz system clock.
*/
`ifndef PFM_CONSTS_VH
`define PFM_CONSTS_VH

`define PFM_CLK_KHZ 200000
`define PFM_TICK_MS 1
`define PFM_MS_CYC (`PFM_CLK_KHZ * `PFM_TICK_MS)
`define PFM_HOLD_MS 3000
`define PFM_BLINK_MS 500
`define PFM_ALT_MS 2000
`define PFM_HALF_STEPS 12

`define PFM_A_CTRL 8'h00
`define PFM_A_DRYDLY 8'h04
`define PFM_A_SWVER 8'h08
`define PFM_A_STATUS 8'h0C
`define PFM_A_LAST 8'h10
`define PFM_A_HIDX 8'h14
`define PFM_A_HDATA 8'h18

`define PFM_CTRL_PHASE 0
`define PFM_CTRL_XALARM 1
`define PFM_CTRL_CLR 2
`define PFM_CTRL_RST 3'h3
`define PFM_DRYDLY_RST 16'h0000
`define PFM_SWVER_RST 8'h01

// codes held as their decimal numbers in binary
`define PFM_E_PHASE 8'h06
`define PFM_E_PSENS 8'h28
`define PFM_E_DRY 8'h3E
`define PFM_E_HIGH 8'h42
`define PFM_E_XOFF 8'h44
`define PFM_E_PUMP 8'h50

`define PFM_F_PHASE 0
`define PFM_F_PSENS 1
`define PFM_F_DRY1 2
`define PFM_F_DRY2 3
`define PFM_F_HIGH 4
`define PFM_F_XOFF 5
`define PFM_F_PUMP1 6
`define PFM_F_PUMP2 7

`define PFM_ST_IDLE 5'h01
`define PFM_ST_MAIN 5'h02
`define PFM_ST_M601 5'h04
`define PFM_ST_EDIT 5'h08
`define PFM_ST_EASY 5'h10
`define PFM_GRP_FAULT 4'h6
`define PFM_GRP_MAX 4'h9
`define PFM_EASY_ITEMS 3'h4
`define PFM_EASY_ERR 3'h2

`endif

// ==== hdl/pfm_hist_mem.v ====
/*
  fault history store: ten-entry circular buffer, read newest first.
  assumes one write per cycle at most and a stable read index.
*/
`timescale 1ns/1ps
module pfm_hist_mem #(
  parameter W = 20,
  parameter DEPTH = 10
) (
  input wire clk,
  input wire rst_n,
  input wire we,
  input wire [W-1:0] wdata,
  input wire [3:0] rd_idx,
  output reg [W-1:0] rdata,
  output reg [3:0] count
);
  localparam [4:0] DEP = DEPTH;
  reg [W-1:0] mem [0:DEPTH-1];
  reg [3:0] wptr_ff;
  wire [4:0] raw = {1'b0, wptr_ff} + DEP - 5'h01 - {1'b0, rd_idx};
  wire [4:0] ra = (raw >= DEP) ? raw - DEP : raw;

  always @(posedge clk) begin
    if (we) begin
      mem[wptr_ff] <= wdata;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_ff <= 4'h0;
      count <= 4'h0;
      rdata <= {W{1'b0}};
    end else begin
      if (we) begin
        wptr_ff <= (wptr_ff == DEP[3:0] - 4'h1) ? 4'h0 : wptr_ff + 4'h1;
        if (count != DEP[3:0]) begin
          count <= count + 4'h1;
        end
      end
      // index 0 is the newest entry
      rdata <= (rd_idx < count) ? mem[ra[3:0]] : {W{1'b0}};
    end
  end
endmodule // pfm_hist_mem

// ==== hdl/pfm_fault_mgr.v ====
/*
  pump fault manager top: fault detection and coding, lamp and display
  drive, operator knob menu, fault history and a classic wishbone slave.
  assumes fault inputs, knob step pulses and button level are synchronous.
*/
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "pfm_consts.vh"
module pfm_fault_mgr #(
  parameter MS_CYC = `PFM_MS_CYC,
  parameter HOLD_MS = `PFM_HOLD_MS,
  parameter BLINK_MS = `PFM_BLINK_MS,
  parameter ALT_MS = `PFM_ALT_MS,
  parameter HALF_STEPS = `PFM_HALF_STEPS,
  parameter EW = 20
) (
  input wire CLK,
  input wire RST_N,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  input wire PHASE_BAD,
  input wire PSENS_SILENT,
  input wire [1:0] DRY_LOW,
  input wire HIGH_WATER,
  input wire XOFF_ALL,
  input wire [1:0] PUMP_NONE,
  input wire [1:0] PUMP_ILIM_UNSET,
  input wire [1:0] PUMP_NO_FB,
  input wire [1:0] PUMP_THERM,
  input wire [1:0] PUMP_OVERCUR,
  input wire BTN_N,
  input wire ROT_STEP,
  input wire ROT_CW,
  output reg LED_RED,
  output reg COMMON_FAULT,
  output reg DISP_ERR,
  output reg [EW-1:0] DISP_CODE,
  output reg [1:0] PUMP_ICON_BLINK
);
  localparam [17:0] MS_LAST = MS_CYC - 1;
  localparam [11:0] HOLD_LAST = HOLD_MS - 1;
  localparam [11:0] BLINK_LAST = BLINK_MS - 1;
  localparam [11:0] ALT_LAST = ALT_MS - 1;
  localparam [4:0] HALF_LAST = HALF_STEPS - 1;

  // code and suffix of one fault source
  function [11:0] code_of;
    input [2:0] idx;
    begin
      case (idx)
        `PFM_F_PHASE: code_of = {`PFM_E_PHASE, 4'h0};
        `PFM_F_PSENS: code_of = {`PFM_E_PSENS, 4'h0};
        `PFM_F_DRY1: code_of = {`PFM_E_DRY, 4'h1};
        `PFM_F_DRY2: code_of = {`PFM_E_DRY, 4'h2};
        `PFM_F_HIGH: code_of = {`PFM_E_HIGH, 4'h0};
        `PFM_F_XOFF: code_of = {`PFM_E_XOFF, 4'h0};
        `PFM_F_PUMP1: code_of = {`PFM_E_PUMP, 4'h1};
        default: code_of = {`PFM_E_PUMP, 4'h2};
      endcase
    end
  endfunction
  function [2:0] lowest;
    input [7:0] v;
    integer i;
    begin
      lowest = 3'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        if (v[i]) begin
          lowest = i[2:0];
        end
      end
    end
  endfunction

  // 12-bit ms counter step with wrap at a limit
  function [11:0] ms_step;
    input [11:0] v;
    input [11:0] last;
    begin
      ms_step = (v == last) ? 12'h000 : v + 12'h001;
    end
  endfunction

  reg [17:0] pre_ff;
  reg [11:0] blk_cnt_ff;
  reg [11:0] alt_cnt_ff;
  reg blink_ff;
  reg alt_ff;
  wire ms_tick = (pre_ff == MS_LAST);
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pre_ff <= 18'h00000;
      blk_cnt_ff <= 12'h000;
      alt_cnt_ff <= 12'h000;
      blink_ff <= 1'b0;
      alt_ff <= 1'b0;
    end else begin
      pre_ff <= ms_tick ? 18'h00000 : pre_ff + 18'h00001;
      if (ms_tick) begin
        blk_cnt_ff <= ms_step(blk_cnt_ff, BLINK_LAST);
        alt_cnt_ff <= ms_step(alt_cnt_ff, ALT_LAST);
        blink_ff <= blink_ff ^ (blk_cnt_ff == BLINK_LAST);
        alt_ff <= alt_ff ^ (alt_cnt_ff == ALT_LAST);
      end
    end
  end

  // wishbone slave
  reg [2:0] ctrl_ff;
  reg [15:0] drydly_ff;
  reg [7:0] swver_ff;
  reg [3:0] hidx_ff;
  reg sw_clr_ff;
  wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wb_wr = wb_req & WB_WE_I;
  wire [EW-1:0] hist_rd;
  wire [3:0] hist_cnt;
  reg [EW-1:0] last_ff;
  reg [7:0] active;
  reg [7:0] prev_ff;
  reg [7:0] pend_ff;
  reg ind_ff;
  reg silenced_ff;
  reg [4:0] st_ff;
  reg [31:0] rd_mux;
  always @* begin
    case (WB_ADR_I)
      `PFM_A_CTRL: rd_mux = {29'h0, 1'b0, ctrl_ff[1:0]};
      `PFM_A_DRYDLY: rd_mux = {16'h0000, drydly_ff};
      `PFM_A_SWVER: rd_mux = {24'h000000, swver_ff};
      `PFM_A_STATUS: rd_mux = {11'h000, st_ff, hist_cnt, 2'h0, silenced_ff, ind_ff, active};
      `PFM_A_LAST: rd_mux = {{(32-EW){1'b0}}, last_ff};
      `PFM_A_HIDX: rd_mux = {28'h0000000, hidx_ff};
      `PFM_A_HDATA: rd_mux = {{(32-EW){1'b0}}, hist_rd};
      default: rd_mux = 32'h00000000;
    endcase
  end
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
      ctrl_ff <= `PFM_CTRL_RST;
      drydly_ff <= `PFM_DRYDLY_RST;
      swver_ff <= `PFM_SWVER_RST;
      hidx_ff <= 4'h0;
      sw_clr_ff <= 1'b0;
    end else begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= wb_req ? rd_mux : 32'h00000000;
      sw_clr_ff <= wb_wr & (WB_ADR_I == `PFM_A_CTRL) & WB_SEL_I[0] & WB_DAT_I[`PFM_CTRL_CLR];
      if (wb_wr & WB_SEL_I[0]) begin
        case (WB_ADR_I)
          `PFM_A_CTRL: ctrl_ff[1:0] <= WB_DAT_I[1:0];
          `PFM_A_DRYDLY: drydly_ff[7:0] <= WB_DAT_I[7:0];
          `PFM_A_SWVER: swver_ff <= WB_DAT_I[7:0];
          `PFM_A_HIDX: hidx_ff <= WB_DAT_I[3:0];
          default: ;
        endcase
      end
      if (wb_wr & WB_SEL_I[1] & (WB_ADR_I == `PFM_A_DRYDLY)) begin
        drydly_ff[15:8] <= WB_DAT_I[15:8];
      end
    end
  end

  // operator knob: press, 3 s hold and rotation steps
  reg btn_prev_ff;
  reg [11:0] hold_ff;
  reg long_done_ff;
  reg [4:0] rot_acc_ff;
  reg [3:0] grp_ff;
  reg [2:0] item_ff;
  reg edit_val_ff;
  reg knob_clr_ff;
  wire btn_dn = ~BTN_N;
  wire long_ev = btn_dn & ~long_done_ff & ms_tick & (hold_ff == HOLD_LAST);
  wire short_ev = BTN_N & ~btn_prev_ff & ~long_done_ff;
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      btn_prev_ff <= 1'b1;
      hold_ff <= 12'h000;
      long_done_ff <= 1'b0;
    end else begin
      btn_prev_ff <= BTN_N;
      if (BTN_N) begin
        hold_ff <= 12'h000;
        long_done_ff <= 1'b0;
      end else if (ms_tick & ~long_done_ff) begin
        hold_ff <= hold_ff + 12'h001;
        long_done_ff <= (hold_ff == HOLD_LAST);
      end
    end
  end
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_ff <= `PFM_ST_IDLE;
      rot_acc_ff <= 5'h00;
      grp_ff <= 4'h1;
      item_ff <= 3'h0;
      edit_val_ff <= 1'b0;
      knob_clr_ff <= 1'b0;
    end else begin
      knob_clr_ff <= 1'b0;
      case (st_ff)
        `PFM_ST_IDLE: begin
          if (long_ev) begin
            st_ff <= `PFM_ST_MAIN;
            grp_ff <= 4'h1;
            rot_acc_ff <= 5'h00;
          end else if (ROT_STEP & ROT_CW) begin
            rot_acc_ff <= rot_acc_ff + 5'h01;
            if (rot_acc_ff == HALF_LAST) begin
              st_ff <= `PFM_ST_EASY;
              item_ff <= 3'h0;
              rot_acc_ff <= 5'h00;
            end
          end else if (ROT_STEP | short_ev) begin
            rot_acc_ff <= 5'h00;
          end
        end
        `PFM_ST_MAIN: begin
          if (ROT_STEP) begin
            if (ROT_CW) begin
              grp_ff <= (grp_ff == `PFM_GRP_MAX) ? 4'h1 : grp_ff + 4'h1;
            end else begin
              grp_ff <= (grp_ff == 4'h1) ? `PFM_GRP_MAX : grp_ff - 4'h1;
            end
          end else if (short_ev) begin
            st_ff <= (grp_ff == `PFM_GRP_FAULT) ? `PFM_ST_M601 : `PFM_ST_IDLE;
          end
        end
        `PFM_ST_M601: begin
          if (short_ev) begin
            st_ff <= `PFM_ST_EDIT;
            edit_val_ff <= 1'b0;
          end
        end
        `PFM_ST_EDIT: begin
          if (ROT_STEP) begin
            edit_val_ff <= ~edit_val_ff;
          end else if (short_ev) begin
            knob_clr_ff <= edit_val_ff;
            st_ff <= `PFM_ST_IDLE;
          end
        end
        `PFM_ST_EASY: begin
          if (ROT_STEP) begin
            if (ROT_CW) begin
              item_ff <= (item_ff == `PFM_EASY_ITEMS - 3'h1) ? 3'h0 : item_ff + 3'h1;
            end else begin
              item_ff <= (item_ff == 3'h0) ? `PFM_EASY_ITEMS - 3'h1 : item_ff - 3'h1;
            end
          end else if (short_ev) begin
            knob_clr_ff <= (item_ff == `PFM_EASY_ERR);
            st_ff <= `PFM_ST_IDLE;
          end
        end
        default: st_ff <= `PFM_ST_IDLE;
      endcase
    end
  end

  // fault sources
  wire clr_req = knob_clr_ff | sw_clr_ff;
  wire [1:0] pump_cause = PUMP_NONE | PUMP_ILIM_UNSET | PUMP_NO_FB | PUMP_THERM
    | PUMP_OVERCUR;
  reg [1:0] pump_lat_ff;
  // a latch acknowledged with its cause gone must not hold the indication
  wire [1:0] nxt_pump_lat = pump_cause | (pump_lat_ff & {2{~clr_req}});
  reg [15:0] dly_ff [0:1];
  reg [1:0] dry_rep;
  reg [1:0] dry_wait;
  integer k;
  always @* begin
    dry_rep[0] = DRY_LOW[0] & (dly_ff[0] >= drydly_ff);
    dry_rep[1] = DRY_LOW[1] & (dly_ff[1] >= drydly_ff);
    dry_wait = DRY_LOW & ~dry_rep;
    active = 8'h00;
    active[`PFM_F_PHASE] = PHASE_BAD & ctrl_ff[`PFM_CTRL_PHASE];
    active[`PFM_F_PSENS] = PSENS_SILENT;
    active[`PFM_F_DRY1] = dry_rep[0];
    active[`PFM_F_DRY2] = dry_rep[1];
    active[`PFM_F_HIGH] = HIGH_WATER;
    active[`PFM_F_XOFF] = XOFF_ALL & ctrl_ff[`PFM_CTRL_XALARM];
    active[`PFM_F_PUMP1] = pump_lat_ff[0];
    active[`PFM_F_PUMP2] = pump_lat_ff[1];
  end
  wire [7:0] still_on = {nxt_pump_lat, active[5:0]};
  // delay counts in ms; it stops once the report is made
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dly_ff[0] <= 16'h0000;
      dly_ff[1] <= 16'h0000;
      pump_lat_ff <= 2'b00;
    end else begin
      for (k = 0; k < 2; k = k + 1) begin
        if (!DRY_LOW[k]) begin
          dly_ff[k] <= 16'h0000;
        end else if (ms_tick & ~dry_rep[k]) begin
          dly_ff[k] <= dly_ff[k] + 16'h0001;
        end
      end
      // cause present wins over an acknowledge in the same cycle
      pump_lat_ff <= nxt_pump_lat;
    end
  end

  // event logging: one new fault per cycle, lowest source first
  wire [2:0] log_idx = lowest(pend_ff);
  wire log_we = |pend_ff;
  wire [EW-1:0] log_entry = {swver_ff, code_of(log_idx)};
  wire [7:0] log_bit = 8'h01 << log_idx;
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prev_ff <= 8'h00;
      pend_ff <= 8'h00;
      last_ff <= {EW{1'b0}};
      ind_ff <= 1'b0;
      silenced_ff <= 1'b0;
    end else begin
      prev_ff <= active;
      pend_ff <= (pend_ff & ~log_bit) | (active & ~prev_ff);
      if (log_we) begin
        last_ff <= log_entry;
      end
      if (log_we | (|still_on & ind_ff)) begin
        ind_ff <= 1'b1;
      end else if (clr_req & ~(|still_on)) begin
        ind_ff <= 1'b0;
      end
      if (log_we | ~ind_ff) begin
        silenced_ff <= 1'b0;
      end else if (short_ev & (st_ff == `PFM_ST_IDLE)) begin
        silenced_ff <= 1'b1;
      end
    end
  end
  pfm_hist_mem #(.W(EW), .DEPTH(10)) u_hist (
    .clk(CLK),
    .rst_n(RST_N),
    .we(log_we),
    .wdata(log_entry),
    .rd_idx(hidx_ff),
    .rdata(hist_rd),
    .count(hist_cnt)
  );
  // indicator outputs, all registered
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      LED_RED <= 1'b0;
      COMMON_FAULT <= 1'b0;
      DISP_ERR <= 1'b0;
      DISP_CODE <= {EW{1'b0}};
      PUMP_ICON_BLINK <= 2'b00;
    end else begin
      LED_RED <= ind_ff | ((|dry_wait) & blink_ff);
      COMMON_FAULT <= ind_ff;
      DISP_ERR <= ind_ff & ~silenced_ff & alt_ff;
      DISP_CODE <= last_ff;
      PUMP_ICON_BLINK <= pump_lat_ff & {2{blink_ff}};
    end
  end
endmodule // pfm_fault_mgr

// ==== testbench/pfm_fault_mgr_monitor.sv ====
/*
  port checker for the pump fault manager, bound into the top module.
  assumes a 20 bit entry {version, code, suffix} on the code display port.
*/
`timescale 1ns/1ps
module pfm_fault_mgr_monitor #(
  parameter EW = 20
) (
  input wire CLK,
  input wire RST_N,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  input wire [31:0] WB_DAT_O,
  input wire WB_ACK_O,
  input wire PSENS_SILENT,
  input wire LED_RED,
  input wire COMMON_FAULT,
  input wire DISP_ERR,
  input wire [EW-1:0] DISP_CODE
);
  logic [7:0] sw_ff;
  logic [7:0] nxt_sw;
  logic [7:0] cd;
  logic [3:0] sx;
  // mirror of the version register so logged entries can be tied to it
  assign nxt_sw = (WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I == 8'h08
    && WB_SEL_I[0]) ? WB_DAT_I[7:0] : sw_ff;
  assign cd = DISP_CODE[11:4];
  assign sx = DISP_CODE[3:0];
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) sw_ff <= 8'h01;
    else sw_ff <= nxt_sw;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_req; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  sequence s_pulse; WB_ACK_O ##1 !WB_ACK_O; endsequence
  property p_ack; s_req |=> s_pulse; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_idle; !WB_ACK_O |-> WB_DAT_O == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside ack");
  property p_unmap; WB_ACK_O && !WB_WE_I && WB_ADR_I >= 8'h1C |-> WB_DAT_O == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_clr; WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h00 |-> !WB_DAT_O[2]; endproperty
  a_clr: assert property (p_clr) else $error("reset bit reads back");
  property p_lamp; COMMON_FAULT |-> LED_RED; endproperty
  a_lamp: assert property (p_lamp) else $error("lamp dark during fault");
  property p_hold;
    PSENS_SILENT && $past(PSENS_SILENT) && $past(PSENS_SILENT, 2) && COMMON_FAULT
      |=> COMMON_FAULT;
  endproperty
  a_hold: assert property (p_hold) else $error("fault output dropped with fault");
  property p_quiet; !COMMON_FAULT && !$past(COMMON_FAULT) |-> !DISP_ERR; endproperty
  a_quiet: assert property (p_quiet) else $error("error shown without fault");
  property p_code;
    $changed(DISP_CODE) |-> ((cd == 8'h06 || cd == 8'h28 || cd == 8'h42 || cd == 8'h44)
      && sx == 4'h0) || ((cd == 8'h3E || cd == 8'h50) && (sx == 4'h1 || sx == 4'h2));
  endproperty
  a_code: assert property (p_code) else $error("bad code or suffix");
  property p_ver;
    $changed(DISP_CODE) |-> DISP_CODE[19:12] == sw_ff || DISP_CODE[19:12] == $past(sw_ff);
  endproperty
  a_ver: assert property (p_ver) else $error("entry version wrong");
endmodule // pfm_fault_mgr_monitor

bind pfm_fault_mgr pfm_fault_mgr_monitor #(.EW(EW)) u_mon (.CLK(CLK), .RST_N(RST_N),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .PSENS_SILENT(PSENS_SILENT), .LED_RED(LED_RED), .COMMON_FAULT(COMMON_FAULT),
  .DISP_ERR(DISP_ERR), .DISP_CODE(DISP_CODE));

// ==== testbench/pfm_operator.sv ====
/*
  operator at the knob: button presses and detent steps.
  assumes calls come one at a time; outputs change just after clk rises.
*/
`timescale 1ns/1ps
module pfm_operator (
  input wire logic clk,
  output logic btn_n,
  output logic rot_step,
  output logic rot_cw
);
  initial begin
    btn_n = 1'b1;
    rot_step = 1'b0;
    rot_cw = 1'b0;
  end
  // hold n cycles, then release and give the menu time to react
  task press(input int n);
    begin
      @(posedge clk) btn_n <= 1'b0;
      repeat (n) @(posedge clk);
      btn_n <= 1'b1;
      repeat (6) @(posedge clk);
    end
  endtask
  // a gap after each pulse so steps never merge
  task turn(input int n, input logic cw);
    begin
      repeat (n) begin
        @(posedge clk) rot_step <= 1'b1;
        rot_cw <= cw;
        @(posedge clk) rot_step <= 1'b0;
        @(posedge clk);
      end
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // pfm_operator

// ==== testbench/testbench.sv ====
/*
  self-checking bench for the pump fault manager.
  assumes short ms ticks set through parameters; the operator model turns the knob.
*/
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, btn_n, rot_step, rot_cw, led, cf, derr;
  logic phase = 1'b0;
  logic psens = 1'b0;
  logic high = 1'b0;
  logic xoff = 1'b0;
  logic [1:0] dry = 2'h0;
  logic [1:0] pnone = 2'h0, pilim = 2'h0, pnofb = 2'h0, ptherm = 2'h0, povc = 2'h0;
  logic [3:0] sel = 4'h0, sel_w = 4'h3;
  logic [19:0] code;
  logic [1:0] icon;
  logic [7:0] sw = 8'h01;
  logic [19:0] hist [$];
  logic e0, e1, l0, l1, i0, i1;
  int fail_count = 0;
  int compares = 0;
  int i, p;
  always #2.5 clk = ~clk;
  pfm_fault_mgr #(.MS_CYC(2), .HOLD_MS(30), .BLINK_MS(5), .ALT_MS(10)) dut (.CLK(clk),
    .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .PHASE_BAD(phase),
    .PSENS_SILENT(psens), .DRY_LOW(dry), .HIGH_WATER(high), .XOFF_ALL(xoff),
    .PUMP_NONE(pnone), .PUMP_ILIM_UNSET(pilim), .PUMP_NO_FB(pnofb), .PUMP_THERM(ptherm),
    .PUMP_OVERCUR(povc), .BTN_N(btn_n), .ROT_STEP(rot_step), .ROT_CW(rot_cw),
    .LED_RED(led), .COMMON_FAULT(cf), .DISP_ERR(derr), .DISP_CODE(code),
    .PUMP_ICON_BLINK(icon));
  pfm_operator op (.clk(clk), .btn_n(btn_n), .rot_step(rot_step), .rot_cw(rot_cw));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      compares++;
      if (seen !== exp) begin
        fail_count++;
        $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // the bus task never assumes a latency: only ack ends its wait, with no timeout of its own; wait_cf gives up after 100 cycles
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= sel_w;
      adr <= a;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  function automatic logic [19:0] entry(input int f);
    logic [7:0] c;
    logic [3:0] s;
    begin
      case (f)
        0: c = 8'h06;
        1: c = 8'h28;
        2, 3: c = 8'h3E;
        4: c = 8'h42;
        5: c = 8'h44;
        default: c = 8'h50;
      endcase
      s = (f == 2 || f == 6) ? 4'h1 : ((f == 3 || f == 7) ? 4'h2 : 4'h0);
      entry = {sw, c, s};
    end
  endfunction
  task set_fault(input int f, input logic v);
    begin
      @(posedge clk);
      case (f)
        0: phase <= v;
        1: psens <= v;
        2: dry[0] <= v;
        3: dry[1] <= v;
        4: high <= v;
        5: xoff <= v;
        default: case (p)
          0: pnone[f-6] <= v;
          1: pilim[f-6] <= v;
          2: pnofb[f-6] <= v;
          3: ptherm[f-6] <= v;
          default: povc[f-6] <= v;
        endcase
      endcase
    end
  endtask
  task wait_cf(input logic v);
    int n;
    begin
      n = 0;
      while (cf !== v && n < 100) begin
        @(negedge clk);
        n++;
      end
      chk("common fault", cf, v);
    end
  endtask
  task observe(input int n);
    begin
      {e0, e1, l0, l1, i0, i1} = 6'h0;
      repeat (n) begin
        @(negedge clk);
        if (derr === 1'b0) e0 = 1'b1;
        if (derr === 1'b1) e1 = 1'b1;
        if (led === 1'b0) l0 = 1'b1;
        if (led === 1'b1) l1 = 1'b1;
        if (icon === 2'h0) i0 = 1'b1;
        if ((|icon) === 1'b1) i1 = 1'b1;
      end
    end
  endtask
  task log_on(input int f);
    begin
      set_fault(f, 1'b1);
      wait_cf(1'b1);
      hist.push_front(entry(f));
      chk("lamp", led, 1);
      chk("code", code, entry(f));
    end
  endtask
  task log_off(input int f);
    begin
      set_fault(f, 1'b0);
      wb(1, 8'h00, 32'h7);
      wait_cf(1'b0);
      chk("lamp off", led, 0);
    end
  endtask
  initial begin
    #100000;
    fail_count++;
    close_out;
  end
  initial begin
    p = $urandom(99);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wb(0, 8'h00, 0);
    chk("ctrl", q, 32'h3);
    wb(1, 8'h0C, 32'hFFFFFFFF);
    wb(0, 8'h0C, 0);
    chk("status", q, 32'h00010000);
    wb(1, 8'h1C, 32'h5A);
    wb(0, 8'h1C, 0);
    chk("unmapped", q, 32'h0);
    sel_w = 4'h1;
    wb(1, 8'h04, 32'hABCD);
    sel_w = 4'h3;
    wb(0, 8'h04, 0);
    chk("byte lane", q, 32'h000000CD);
    wb(1, 8'h04, 32'h0);
    $display("test registers done");
    for (i = 0; i < 8; i++) begin
      p = $urandom % 5;
      sw = 8'($urandom);
      wb(1, 8'h08, {24'h0, sw});
      log_on(i);
      wb(1, 8'h00, 32'h7);
      observe(30);
      chk("kept", cf, 1);
      chk("shown", code, entry(i));
      chk("alternate", {e0, e1}, 2'h3);
      if (i > 5) chk("icon", {i0, i1}, 2'h3);
      set_fault(i, 1'b0);
      observe(30);
      if (i > 5) chk("latched icon", {i0, i1}, 2'h3);
      log_off(i);
    end
    $display("test fault codes done");
    wb(1, 8'h00, 32'h0);
    set_fault(0, 1'b1);
    set_fault(5, 1'b1);
    observe(20);
    chk("masked", cf, 0);
    set_fault(0, 1'b0);
    set_fault(5, 1'b0);
    wb(1, 8'h00, 32'h3);
    wb(1, 8'h04, 32'd20);
    set_fault(2, 1'b1);
    observe(30);
    chk("blink", {l0, l1, cf}, 3'h6);
    log_on(2);
    log_off(2);
    wb(1, 8'h04, 32'h0);
    $display("test masks and delay done");
    repeat (3) begin
      log_on(1);
      log_off(1);
    end
    wb(0, 8'h0C, 0);
    chk("count", q[15:12], 4'hA);
    for (i = 0; i < 10; i++) begin
      wb(1, 8'h14, i);
      wb(0, 8'h18, 0);
      chk("history", q, {12'h0, hist[i]});
    end
    $display("test history done");
    log_on(4);
    set_fault(4, 1'b0);
    op.press(4);
    observe(30);
    chk("silenced", {e1, cf}, 2'h1);
    op.press(70);
    op.turn(6, 1'b1);
    op.turn(1, 1'b0);
    op.press(4);
    op.press(4);
    op.turn(1, 1'b1);
    op.press(4);
    wait_cf(1'b0);
    log_on(1);
    set_fault(1, 1'b0);
    op.turn(12, 1'b1);
    op.turn(3, 1'b1);
    op.turn(1, 1'b0);
    op.press(4);
    wait_cf(1'b0);
    $display("test knob done");
    close_out;
  end
endmodule // testbench
